//--- hw/perf_event_pkg.sv
// Constants and carrier types for the performance event decoder.
// Assumes one core clock domain; every user reads names as package::name.

package perf_event_pkg;

   // ==================================================================
   // Event select codes
   localparam logic [7:0] EVT_CLEAR = 8'hc3;
   localparam logic [7:0] EVT_BR    = 8'hc4;
   localparam logic [7:0] EVT_MISP  = 8'hc5;
   localparam logic [7:0] EVT_IDLE  = 8'hca;

   // ==================================================================
   // Unit masks
   localparam logic [7:0] UM_CODE_MOD   = 8'h01;
   localparam logic [7:0] UM_ORDERING   = 8'h02;
   localparam logic [7:0] UM_FLOAT_HELP = 8'h04;
   localparam logic [7:0] UM_CLEAR_ANY  = 8'h08;
   localparam logic [7:0] UM_BR_ALL     = 8'h00;
   localparam logic [7:0] UM_COND       = 8'h7e;
   localparam logic [7:0] UM_FAR        = 8'hbf;
   localparam logic [7:0] UM_NEAR_IND   = 8'heb;
   localparam logic [7:0] UM_NEAR_RET   = 8'hf7;
   localparam logic [7:0] UM_NEAR_CALL  = 8'hf9;
   localparam logic [7:0] UM_IND_CALL   = 8'hfb;
   localparam logic [7:0] UM_REL_CALL   = 8'hfd;
   localparam logic [7:0] UM_TAKEN_COND = 8'hfe;
   localparam logic [7:0] UM_ROB_FULL   = 8'h01;
   localparam logic [7:0] UM_RENAME     = 8'h20;
   localparam logic [7:0] UM_IDLE_ANY   = 8'h3f;
   localparam logic [7:0] UM_STARVED    = 8'h50;

   // ==================================================================
   // Detection figures
   localparam int REGION_LSB = 10;
   localparam int ROB_LOW    = 2;

   // ==================================================================
   // Carriers
   typedef struct packed {
      logic valid;
      logic cond;
      logic far;
      logic ind_jmp;
      logic ind_call;
      logic rel_call;
      logic near_ret;
      logic pred_taken;
      logic mispredicted;
   } branch_t;

   typedef struct packed {
      logic alloc_none;
      logic frontend_empty;
      logic backend_stall;
      logic rename_stall;
   } alloc_t;

   typedef struct packed {
      logic code_mod;
      logic ordering;
      logic float_help;
      logic any;
   } clear_t;

   typedef enum logic [0:0] {
      ST_RUN   = 1'b0,
      ST_DRAIN = 1'b1
   } drain_st_t;

endpackage

//--- hw/perf_event_decoder.sv
// Machine clear raising and event qualification for one counter.
// Assumes all inputs come from logic on the core clock; one branch
// retires per cycle at most.
//
// Operation
// - Clear event, mask 01: count code-modification clears.
// - Clear event, mask 02: count memory-ordering clears.
// - Clear event, mask 04: count floating-point help clears.
// - Clear event, mask 08: count every clear, including interrupts and faults.
// - Specific clear counts need not sum to the any-cause count.
// - Float help raises a clear against the instruction, then a helper sequence.
// - A store into the aligned 1K region being executed may raise a clear.
// - After a code-modification clear, drain stores before restarting front end.
// - Snoop hitting a completed load with older load pending raises ordering clear.
// - Without an older pending load no ordering clear is raised.
// - Branch event: mask 00 all retired branches, 7E conditional jumps.
// - Branch event: mask BF far branches, EB near indirect jumps or calls.
// - Branch event: mask F7 near returns, F9 near calls.
// - Branch event: FB indirect calls, FD relative calls, FE taken conditionals.
// - Mispredict event: mask 00 all, 7E conditional jumps.
// - Mispredict event: mask BF far, EB near indirect jumps or calls.
// - Mispredict event: mask F7 near returns, F9 near calls.
// - Mispredict event: FB indirect calls, FD relative calls, FE taken conditionals.
// - Idle event, mask 01: no allocation and fewer than two free reorder entries.
// - Idle event, mask 20: no allocation while rename stall asserted.
// - Idle event, mask 3F: every cycle with nothing allocated.
// - Idle event, mask 50: front end starved while back end not stalled.

`timescale 1ns/100ps
`default_nettype none

module perf_event_decoder #(
   parameter int ADDR_W = 32,
   parameter int TAG_W  = 6,
   parameter int ROB_W  = 7,
   parameter int CNT_W  = 48
) (
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      rst_b,
   // Counter selection
   input  wire logic [7:0]                event_select,
   input  wire logic [7:0]                unit_mask,
   // Store and fetch tracking
   input  wire logic                      store_valid,
   input  wire logic [ADDR_W-1:0]         store_addr,
   input  wire logic [ADDR_W-1:0]         exec_addr,
   input  wire logic                      store_queue_empty,
   // Snoop and load ordering
   input  wire logic                      snoop_valid,
   input  wire logic                      snoop_hit_done_load,
   input  wire logic                      older_load_pending,
   // Floating point help
   input  wire logic                      fp_needs_help,
   input  wire logic [TAG_W-1:0]          fp_instr_tag,
   // Other clear causes: interrupt, trap, fault
   input  wire logic                      other_clear,
   // Retirement and allocation status
   input  wire perf_event_pkg::branch_t   retire_branch,
   input  wire perf_event_pkg::alloc_t    alloc_status,
   input  wire logic [ROB_W-1:0]          rob_free,
   // Clear and restart outputs
   output logic                           machine_clear,
   output perf_event_pkg::clear_t         clear_cause,
   output logic                           frontend_restart,
   output logic                           helper_start,
   output logic [TAG_W-1:0]               helper_tag,
   output logic                           draining,
   // Counter
   output logic                           count_inc,
   output logic [CNT_W-1:0]               event_count
);

   // ==================================================================
   // State
   typedef struct packed {
      perf_event_pkg::drain_st_t st;
      perf_event_pkg::clear_t    cause;
      logic                      clear;
      logic                      restart;
      logic                      helper;
      logic [TAG_W-1:0]          tag;
      logic                      inc;
      logic [CNT_W-1:0]          count;
   } state_t;

   localparam logic [ROB_W-1:0] ROB_LOW_V = ROB_W'(perf_event_pkg::ROB_LOW);

   state_t state_ff;
   state_t nxt_state;

   // ==================================================================
   // Clear detection
   logic                  region_hit;
   logic                  det_code_mod;
   logic                  det_ordering;
   logic                  det_float;
   logic                  det_any;
   perf_event_pkg::clear_t det_cause;

   // Only the 1K region is compared, so stores near but outside the
   // running code may still clear; that costs time, never correctness.
   assign region_hit   = store_addr[ADDR_W-1:perf_event_pkg::REGION_LSB]
                         == exec_addr[ADDR_W-1:perf_event_pkg::REGION_LSB];
   assign det_code_mod = store_valid && region_hit;
   assign det_ordering = snoop_valid && snoop_hit_done_load
                         && older_load_pending;
   assign det_float    = fp_needs_help;
   assign det_any      = det_code_mod || det_ordering || det_float
                         || other_clear;

   always_comb begin
      det_cause            = '0;
      det_cause.code_mod   = det_code_mod;
      det_cause.ordering   = det_ordering;
      det_cause.float_help = det_float;
      det_cause.any        = det_any;
   end

   // ==================================================================
   // Event qualification
   logic idle_rob;
   logic idle_rename;
   logic idle_any;
   logic idle_starved;
   logic br_near_call;
   logic br_near_ind;
   logic br_taken_cond;
   logic br_hit;
   logic sel_hit;

   assign idle_rob      = alloc_status.alloc_none && (rob_free < ROB_LOW_V);
   assign idle_rename   = alloc_status.alloc_none && alloc_status.rename_stall;
   assign idle_any      = alloc_status.alloc_none;
   assign idle_starved  = alloc_status.frontend_empty
                          && !alloc_status.backend_stall;
   assign br_near_call  = retire_branch.ind_call || retire_branch.rel_call;
   assign br_near_ind   = retire_branch.ind_jmp || retire_branch.ind_call;
   assign br_taken_cond = retire_branch.cond && retire_branch.pred_taken;

   // Branch class match, shared by the retired and mispredicted events
   always_comb begin
      br_hit = 1'b0;
      case (unit_mask)
         perf_event_pkg::UM_BR_ALL: begin
            br_hit = 1'b1;
         end
         perf_event_pkg::UM_COND: begin
            br_hit = retire_branch.cond;
         end
         perf_event_pkg::UM_FAR: begin
            br_hit = retire_branch.far;
         end
         perf_event_pkg::UM_NEAR_IND: begin
            br_hit = br_near_ind;
         end
         perf_event_pkg::UM_NEAR_RET: begin
            br_hit = retire_branch.near_ret;
         end
         perf_event_pkg::UM_NEAR_CALL: begin
            br_hit = br_near_call;
         end
         perf_event_pkg::UM_IND_CALL: begin
            br_hit = retire_branch.ind_call;
         end
         perf_event_pkg::UM_REL_CALL: begin
            br_hit = retire_branch.rel_call;
         end
         perf_event_pkg::UM_TAKEN_COND: begin
            br_hit = br_taken_cond;
         end
         default: begin
            br_hit = 1'b0;
         end
      endcase
   end

   // Specific clears are counted on their own detectors while the
   // any-cause count also sees interrupts, so the sums differ.
   always_comb begin
      sel_hit = 1'b0;
      case (event_select)
         perf_event_pkg::EVT_CLEAR: begin
            case (unit_mask)
               perf_event_pkg::UM_CODE_MOD: begin
                  sel_hit = det_code_mod;
               end
               perf_event_pkg::UM_ORDERING: begin
                  sel_hit = det_ordering;
               end
               perf_event_pkg::UM_FLOAT_HELP: begin
                  sel_hit = det_float;
               end
               perf_event_pkg::UM_CLEAR_ANY: begin
                  sel_hit = det_any;
               end
               default: begin
                  sel_hit = 1'b0;
               end
            endcase
         end
         perf_event_pkg::EVT_BR: begin
            sel_hit = retire_branch.valid && br_hit;
         end
         perf_event_pkg::EVT_MISP: begin
            sel_hit = retire_branch.valid && retire_branch.mispredicted && br_hit;
         end
         perf_event_pkg::EVT_IDLE: begin
            case (unit_mask)
               perf_event_pkg::UM_ROB_FULL: begin
                  sel_hit = idle_rob;
               end
               perf_event_pkg::UM_RENAME: begin
                  sel_hit = idle_rename;
               end
               perf_event_pkg::UM_IDLE_ANY: begin
                  sel_hit = idle_any;
               end
               perf_event_pkg::UM_STARVED: begin
                  sel_hit = idle_starved;
               end
               default: begin
                  sel_hit = 1'b0;
               end
            endcase
         end
         default: begin
            sel_hit = 1'b0;
         end
      endcase
   end

   // ==================================================================
   // Next state
   always_comb begin
      nxt_state         = state_ff;
      nxt_state.cause   = det_cause;
      nxt_state.clear   = det_any;
      nxt_state.restart = 1'b0;
      nxt_state.helper  = det_float;
      nxt_state.tag     = det_float ? fp_instr_tag : state_ff.tag;
      nxt_state.inc     = sel_hit;
      // One step per occurrence or per qualifying cycle
      nxt_state.count   = state_ff.count + CNT_W'(sel_hit);
      case (state_ff.st)
         perf_event_pkg::ST_RUN: begin
            if (det_code_mod) begin
               nxt_state.st = perf_event_pkg::ST_DRAIN;
            end
         end
         perf_event_pkg::ST_DRAIN: begin
            // A fresh modifying store restarts the wait for an empty queue
            if (store_queue_empty && !det_code_mod) begin
               nxt_state.st      = perf_event_pkg::ST_RUN;
               nxt_state.restart = 1'b1;
            end
         end
         default: begin
            nxt_state.st = perf_event_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==================================================================
   // Outputs
   assign machine_clear    = state_ff.clear;
   assign clear_cause      = state_ff.cause;
   assign frontend_restart = state_ff.restart;
   assign helper_start     = state_ff.helper;
   assign helper_tag       = state_ff.tag;
   assign draining         = (state_ff.st == perf_event_pkg::ST_DRAIN);
   assign count_inc        = state_ff.inc;
   assign event_count      = state_ff.count;

   // ==================================================================
   // Checks
   sequence code_store_s;
      store_valid && region_hit;
   endsequence

   sequence drained_s;
      draining && store_queue_empty && !det_code_mod;
   endsequence

   code_clear_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      code_store_s |=> clear_cause.code_mod && machine_clear)
      else $error("modifying store raised no clear");

   far_store_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      !(store_valid && region_hit) |=> !clear_cause.code_mod)
      else $error("clear raised without region hit");

   drain_restart_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      code_store_s ##1 (!store_queue_empty && !(store_valid && region_hit)) |=>
      draining && !frontend_restart)
      else $error("restart before stores drained");

   restart_cause_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      drained_s |=> frontend_restart && !draining)
      else $error("drained queue gave no restart");

   order_clear_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      snoop_valid && snoop_hit_done_load && older_load_pending
      |=> clear_cause.ordering)
      else $error("ordering hazard raised no clear");

   no_undo_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      !older_load_pending |=> !clear_cause.ordering)
      else $error("ordering clear without older load");

   float_help_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      fp_needs_help |=> clear_cause.float_help && helper_start
      && helper_tag == $past(fp_instr_tag))
      else $error("float help clear or helper missing");

   any_clear_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      other_clear |=> machine_clear && clear_cause.any)
      else $error("other cause raised no clear");

   clear_count_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      (event_select == perf_event_pkg::EVT_CLEAR
      && unit_mask == perf_event_pkg::UM_CODE_MOD) and code_store_s
      |=> event_count == $past(event_count) + CNT_W'(1))
      else $error("code clear not counted");

   misp_count_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      event_select == perf_event_pkg::EVT_MISP
      && unit_mask == perf_event_pkg::UM_BR_ALL
      && retire_branch.valid && !retire_branch.mispredicted
      |=> !count_inc && $stable(event_count))
      else $error("predicted branch counted as mispredict");

   rob_idle_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      event_select == perf_event_pkg::EVT_IDLE
      && unit_mask == perf_event_pkg::UM_ROB_FULL
      && alloc_status.alloc_none && rob_free == ROB_LOW_V
      |=> !count_inc)
      else $error("reorder idle counted with two free");

   unlisted_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      event_select == perf_event_pkg::EVT_IDLE
      && unit_mask == 8'h02
      |=> $stable(event_count))
      else $error("unlisted pair counted");

endmodule

`default_nettype wire

//--- sim/pipe_status_model.sv
// Behavioural pipeline status source for the event decoder.
// Assumes bench commands change on falling edges and last one cycle.
`timescale 1ns/100ps
`default_nettype none

module pipe_status_model (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // Bench command and drain delay
   input  wire logic [2:0]  cmd,
   input  wire logic [3:0]  drain_len,
   // Status toward the decoder
   output logic             store_valid,
   output logic [31:0]      store_addr,
   output logic [31:0]      exec_addr,
   output logic             store_queue_empty,
   output logic             snoop_valid,
   output logic             snoop_hit_done_load,
   output logic             older_load_pending,
   output logic             fp_needs_help,
   output logic [5:0]       fp_instr_tag,
   output logic             other_clear
);
   localparam logic [31:0] PC   = 32'h0000_1400;
   localparam logic [5:0]  FTAG = 6'h2a;
   logic [2:0] cmd_q;
   logic [3:0] left;

   // ==================================================================
   // Command capture; registered so the falling-edge drive never races
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         cmd_q <= 3'h0;
      else
         cmd_q <= cmd;
   end

   // ==================================================================
   // Status drive
   always @(negedge clock or negedge rst_b) begin
      if (!rst_b) begin
         store_valid         <= 1'b0;
         store_addr          <= 32'h0;
         exec_addr           <= PC;
         store_queue_empty   <= 1'b1;
         snoop_valid         <= 1'b0;
         snoop_hit_done_load <= 1'b0;
         older_load_pending  <= 1'b0;
         fp_needs_help       <= 1'b0;
         fp_instr_tag        <= 6'h0;
         other_clear         <= 1'b0;
         left                <= 4'h0;
      end else begin
         store_valid <= (cmd_q == 3'h1) || (cmd_q == 3'h2);
         // Last word of the running 1K region, or first of the next
         store_addr <= (cmd_q == 3'h1) ? PC + 32'h3fc : (cmd_q == 3'h2) ? 32'h1800 : ~store_addr;
         snoop_valid <= (cmd_q == 3'h3) || (cmd_q == 3'h4);
         // Idle hit line toggles so a stale value is never trusted
         snoop_hit_done_load <= (cmd_q == 3'h3) || (cmd_q == 3'h4) || !snoop_hit_done_load;
         // Older load outstanding only in the hazard case
         older_load_pending <= (cmd_q == 3'h3);
         // Help request against a tagged instruction
         fp_needs_help <= (cmd_q == 3'h5);
         fp_instr_tag  <= (cmd_q == 3'h5) ? FTAG : ~fp_instr_tag;
         other_clear   <= (cmd_q == 3'h6);
         // Stores take drain_len cycles to leave the pipe
         if (cmd_q == 3'h1)
            left <= drain_len;
         else if (left != 4'h0)
            left <= left - 4'h1;
         store_queue_empty <= (cmd_q != 3'h1) && (left <= 4'h1);
      end
   end
endmodule

`default_nettype wire

//--- sim/tb_perf_event_decoder.sv
// Self-checking bench for the performance event decoder.
// Assumes the pipeline status model drives the clear causes.
`timescale 1ns/100ps
`default_nettype none

module tb_perf_event_decoder;
   logic                    clock         = 1'b0;
   logic                    rst_b         = 1'b0;
   logic [7:0]              event_select  = 8'h00;
   logic [7:0]              unit_mask     = 8'h00;
   logic [2:0]              cmd           = 3'h0;
   logic [3:0]              drain_len     = 4'h0;
   perf_event_pkg::branch_t retire_branch = '0;
   perf_event_pkg::alloc_t  alloc_status  = '0;
   logic [6:0]              rob_free      = 7'h40;
   logic                    store_valid, store_queue_empty, snoop_valid;
   logic                    snoop_hit_done_load, older_load_pending;
   logic                    fp_needs_help, other_clear;
   logic [31:0]             store_addr, exec_addr;
   logic [5:0]              fp_instr_tag, helper_tag;
   logic                    machine_clear, frontend_restart, helper_start;
   logic                    draining, count_inc;
   perf_event_pkg::clear_t  clear_cause;
   logic [47:0]             event_count;
   int                      failures = 0;
   int                      compares = 0;
   int                      cyc = 0;
   int                      helpers = 0;
   int                      clears = 0;
   int                      causes = 0;
   int                      incs = 0;

   always #2.5 clock = ~clock;

   pipe_status_model partner_u (.clock(clock), .rst_b(rst_b), .cmd(cmd),
      .drain_len(drain_len), .store_valid(store_valid), .store_addr(store_addr),
      .exec_addr(exec_addr), .store_queue_empty(store_queue_empty),
      .snoop_valid(snoop_valid), .snoop_hit_done_load(snoop_hit_done_load),
      .older_load_pending(older_load_pending), .fp_needs_help(fp_needs_help),
      .fp_instr_tag(fp_instr_tag), .other_clear(other_clear));

   perf_event_decoder dut_u (.clock(clock), .rst_b(rst_b), .event_select(event_select),
      .unit_mask(unit_mask), .store_valid(store_valid), .store_addr(store_addr),
      .exec_addr(exec_addr), .store_queue_empty(store_queue_empty),
      .snoop_valid(snoop_valid), .snoop_hit_done_load(snoop_hit_done_load),
      .older_load_pending(older_load_pending), .fp_needs_help(fp_needs_help),
      .fp_instr_tag(fp_instr_tag), .other_clear(other_clear),
      .retire_branch(retire_branch), .alloc_status(alloc_status), .rob_free(rob_free),
      .machine_clear(machine_clear), .clear_cause(clear_cause),
      .frontend_restart(frontend_restart), .helper_start(helper_start),
      .helper_tag(helper_tag), .draining(draining), .count_inc(count_inc),
      .event_count(event_count));

   // ==================================================================
   // Pulse tallies and hang guard
   always @(negedge clock) begin
      if (helper_start === 1'b1)
         helpers++;
      if (machine_clear === 1'b1) begin
         clears++;
         causes += clear_cause;
      end
      if (count_inc === 1'b1)
         incs++;
   end

   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         summarize();
      end
   end

   // ==================================================================
   // Common tasks
   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic send(input logic [2:0] c);
      cmd = c;
      step(1);
      cmd = 3'h0;
      step(5);
   endtask

   task automatic select(input logic [7:0] e, input logic [7:0] m);
      event_select = e;
      unit_mask    = m;
      step(2);
   endtask

   function automatic logic [47:0] br_hit(input logic [7:0] m,
                                          input perf_event_pkg::branch_t b, input bit misp);
      logic h;
      case (m)
         8'h00:   h = 1'b1;
         8'h7e:   h = b.cond;
         8'hbf:   h = b.far;
         8'heb:   h = b.ind_jmp | b.ind_call;
         8'hf7:   h = b.near_ret;
         8'hf9:   h = b.ind_call | b.rel_call;
         8'hfb:   h = b.ind_call;
         8'hfd:   h = b.rel_call;
         default: h = b.cond & b.pred_taken;
      endcase
      return {47'h0, h & b.valid & (b.mispredicted | !misp)};
   endfunction

   function automatic logic [47:0] idle_hit(input logic [7:0] m,
                                            input perf_event_pkg::alloc_t a, input logic [6:0] r);
      logic h;
      case (m)
         8'h01:   h = a.alloc_none & (r < 7'h2);
         8'h20:   h = a.alloc_none & a.rename_stall;
         8'h3f:   h = a.alloc_none;
         default: h = a.frontend_empty & !a.backend_stall;
      endcase
      return {47'h0, h};
   endfunction

   // ==================================================================
   // Scenarios
   task automatic t_clears();
      logic [7:0]  masks [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
      logic [47:0] base;
      for (int i = 0; i < 4; i++) begin
         select(perf_event_pkg::EVT_CLEAR, masks[i]);
         base = event_count;
         for (int c = 1; c < 7; c++)
            send(c[2:0]);
         check("clear count", event_count - base, (i == 3) ? 48'h4 : 48'h1);
      end
      check("clear pulses", clears, 48'd16);
      // Weighted cause sum per pass: code 9, ordering 5, float 3, other 1
      check("clear causes", causes, 48'd72);
      check("helper pulses", helpers, 48'd4);
      check("helper tag", helper_tag, 48'h2a);
   endtask

   task automatic t_drain();
      int n;
      select(perf_event_pkg::EVT_CLEAR, perf_event_pkg::UM_CODE_MOD);
      drain_len = 4'h6;
      cmd = 3'h1;
      step(1);
      cmd = 3'h0;
      step(2);
      check("draining", draining, 1'b1);
      check("early restart", frontend_restart, 1'b0);
      n = 0;
      while (frontend_restart !== 1'b1 && n < 20) begin
         step(1);
         n++;
      end
      check("restart delay", (n >= 2) && (n < 20), 1'b1);
      step(1);
      check("drain over", draining, 1'b0);
      drain_len = 4'h0;
   endtask

   task automatic t_branches();
      perf_event_pkg::branch_t kinds [8] = '{9'h183, 9'h180, 9'h141, 9'h120,
                                             9'h111, 9'h108, 9'h105, 9'h083};
      logic [7:0]  masks [9] = '{8'h00, 8'h7e, 8'hbf, 8'heb, 8'hf7, 8'hf9, 8'hfb, 8'hfd, 8'hfe};
      logic [47:0] base, want;
      for (int e = 0; e < 2; e++) begin
         for (int m = 0; m < 9; m++) begin
            select(e ? perf_event_pkg::EVT_MISP : perf_event_pkg::EVT_BR, masks[m]);
            base = event_count;
            want = '0;
            for (int k = 0; k < 8; k++) begin
               retire_branch = kinds[k];
               want += br_hit(masks[m], kinds[k], e == 1);
               step(1);
            end
            retire_branch = '0;
            step(3);
            check("branch count", event_count - base, want);
         end
      end
   endtask

   task automatic t_idle();
      logic [3:0]  pat [7] = '{4'h8, 4'h8, 4'h1, 4'h9, 4'h4, 4'h6, 4'hc};
      logic [6:0]  reorder_buffer [7] = '{7'h1, 7'h2, 7'h0, 7'h5, 7'h9, 7'h9, 7'h1};
      logic [7:0]  masks [4] = '{8'h01, 8'h20, 8'h3f, 8'h50};
      logic [47:0] base, want;
      int          i0;
      for (int m = 0; m < 4; m++) begin
         select(perf_event_pkg::EVT_IDLE, masks[m]);
         base = event_count;
         i0   = incs;
         want = '0;
         for (int k = 0; k < 7; k++) begin
            alloc_status = pat[k];
            rob_free     = reorder_buffer[k];
            want += idle_hit(masks[m], pat[k], reorder_buffer[k]);
            step(1);
         end
         alloc_status = '0;
         rob_free     = 7'h40;
         step(3);
         check("idle count", event_count - base, want);
         check("idle pulses", incs - i0, want);
      end
   endtask

   task automatic t_unlisted();
      logic [15:0] pairs [5] = '{16'hc310, 16'hc401, 16'hc5ff, 16'hca02, 16'h3c00};
      logic [47:0] base;
      for (int p = 0; p < 5; p++) begin
         select(pairs[p][15:8], pairs[p][7:0]);
         base          = event_count;
         retire_branch = 9'h1ff;
         alloc_status  = 4'hd;
         rob_free      = 7'h0;
         step(1);
         retire_branch = '0;
         alloc_status  = '0;
         rob_free      = 7'h40;
         send(3'h1);
         check("unlisted count", event_count - base, 48'h0);
      end
   endtask

   task automatic summarize();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ==================================================================
   // Main sequence
   initial begin
      step(20);
      rst_b = 1'b1;
      step(2);
      check("reset count", event_count, 48'h0);
      t_clears();
      t_drain();
      t_branches();
      t_idle();
      t_unlisted();
      summarize();
   end
endmodule

`default_nettype wire
